// ---- shared/mac_table_map.svh ----
// Register offsets, field positions, reset values and timing for the address table
`ifndef MAC_TABLE_MAP_SVH
`define MAC_TABLE_MAP_SVH
`define REG_CTRL      8'h00
`define REG_AGE       8'h04
`define REG_LEARN     8'h08
`define REG_OWNED     8'h0c
`define REG_KEY_VID   8'h10
`define REG_KEY_MLO   8'h14
`define REG_KEY_MHI   8'h18
`define REG_KEY_PORTS 8'h1c
`define REG_CMD       8'h20
`define REG_RES_VID   8'h24
`define REG_RES_MLO   8'h28
`define REG_RES_MHI   8'h2c
`define REG_RES_PORTS 8'h30
`define REG_LAST      8'h30
`define CTRL_AGE_DIS  0
`define CMD_LOOKUP    0
`define CMD_NEXT      1
`define CMD_ADD       2
`define CMD_MARK      3
`define CMD_COMMIT    4
`define ST_BUSY       0
`define ST_FOUND      1
`define ST_EOT        2
`define ST_FULL       3
`define ST_STATIC     4
`define AGE_DEF       20'h0012c
`define AGE_MIN       20'h0000a
`define AGE_MAX       20'hf4240
`define LEARN_DEF     24'h000000
`define NUM_PORTS     12
`define STATIC_MAX    64
`define TABLE_SIZE    128
`define TICK_NS       1000000000
`define CLK_NS        10
`endif

// ---- shared/mac_table_pkg.sv ----
// Types shared by the address table design
package mac_table_pkg;
    typedef logic [11:0] vid_t;
    typedef logic [47:0] mac_t;
    typedef logic [11:0] pmask_t;
    typedef logic [59:0] key_t;
    typedef logic [6:0]  idx_t;
    typedef logic [19:0] age_t;
    typedef enum logic [1:0] {LM_AUTO, LM_DISABLE, LM_SECURE, LM_SPARE} learn_mode_t;
    typedef enum logic [2:0] {OP_LOOKUP, OP_NEXT, OP_ADD, OP_MARK, OP_LEARN} op_t;
    typedef enum logic [1:0] {ST_IDLE, ST_SCAN, ST_DONE} state_t;
endpackage

// ---- design/mac_table.sv ----
// Station address table: learning, aging, static entries and ordered lookup
//
// Functional notes
// RULE_01 - Unrefreshed dynamic entries age out, default 300 s
// RULE_02 - Age time clamped to 10..1000000 seconds
// RULE_03 - Aging disable keeps dynamic entries forever
// RULE_04 - Auto mode learns unknown source at once
// RULE_05 - Disabled port never creates dynamic entries
// RULE_06 - Secure port drops frames without static match
// RULE_07 - At most 64 static entries, else refused
// RULE_08 - Order by VLAN first, then address
// RULE_09 - Static entry: VLAN, address, 12-port mask
// RULE_10 - Marked static entries removed only on commit
// RULE_11 - Lookup returns exact or next following entry
// RULE_12 - Scan continues after key, flags end
// RULE_13 - Owned port ignores learning mode writes
// RULE_14 - Results carry static or dynamic type
// RULE_15 - Aging never removes static entries
// RULE_16 - Refresh on hit, 1 s tick, 2-bit mode
`timescale 1ns/1ps
`include "mac_table_map.svh"

module mac_table
    import mac_table_pkg::*;
#(
    parameter int TICK_CYCLES = `TICK_NS / `CLK_NS
) (
    // Clock and reset
    input  wire logic        clk_sys,
    input  wire logic        arst_n,
    // APB slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    // Received frame source report
    input  wire logic        frm_valid,
    output logic             frm_ready,
    input  wire logic [3:0]  frm_port,
    input  wire vid_t        frm_vid,
    input  wire mac_t        frame_source_station_address,
    output logic             frm_done,
    output logic             frm_drop,
    // Ports whose learning mode another function owns
    input  wire logic [11:0] learn_owned
);

    ////////////////////////////////////////////////////////////////////////////
    // Helpers

    // Ordering key: VLAN in the upper bits, so plain compare sorts by VLAN then MAC
    function automatic key_t key_of(input vid_t v, input mac_t m);
        key_of = {v, m};
    endfunction

    function automatic pmask_t port_bit(input logic [3:0] p);
        pmask_t b;
        b = '0;
        for (int i = 0; i < `NUM_PORTS; i++) begin
            if (p == 4'(i)) begin
                b[i] = 1'b1;
            end
        end
        port_bit = b;
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // State

    logic                   age_dis_r;
    age_t                   age_time_r;
    logic [23:0]            learn_mode_r;
    vid_t                   kvid_r;
    mac_t                   kmac_r;
    pmask_t                 kports_r;
    vid_t                   res_vid_r;
    mac_t                   res_mac_r;
    pmask_t                 res_ports_r;
    logic                   res_found_r, res_eot_r, add_full_r, res_static_r;
    logic [31:0]            prdata_r;
    logic                   cmd_pend_r;
    op_t                    cmd_op_r, op_r;
    state_t                 st_r;
    idx_t                   idx_r, hit_idx_r, bidx_r, fs_idx_r, fd_idx_r;
    logic                   hit_r, bf_r, fs_f_r, fd_f_r;
    key_t                   skey_r, bkey_r;
    logic [3:0]             fport_r;
    logic                   frm_done_r, frm_drop_r;
    logic [26:0]            tick_cnt_r;
    logic                   tick_r;
    logic [`TABLE_SIZE-1:0] valid_r;
    logic [`STATIC_MAX-1:0] del_r;
    vid_t                   vid_r   [`TABLE_SIZE];
    mac_t                   mac_r   [`TABLE_SIZE];
    pmask_t                 ports_r [`TABLE_SIZE];
    age_t                   age_r   [`TABLE_SIZE];

    ////////////////////////////////////////////////////////////////////////////
    // APB decode

    // Zero wait states; read data is captured in the setup cycle
    wire logic  setup_w   = psel & ~penable;
    wire logic  map_ok_w  = (paddr[1:0] == 2'h0) && (paddr <= `REG_LAST);
    wire logic  wr_w      = psel & penable & pwrite & map_ok_w;
    wire logic  wr_learn  = wr_w && (paddr == `REG_LEARN);
    wire logic  wr_cmd    = wr_w && (paddr == `REG_CMD);
    wire logic  commit_w  = wr_cmd && pwdata[`CMD_COMMIT];
    wire logic  idle_w    = (st_r == ST_IDLE);
    wire logic  busy_w    = !idle_w || cmd_pend_r;
    wire logic  start_cmd = idle_w && cmd_pend_r;
    wire logic  start_frm = idle_w && !cmd_pend_r && frm_valid;
    wire age_t  age_wr    = pwdata[19:0];
    wire logic  age_big   = (pwdata[31:20] != 12'h000) || (age_wr > `AGE_MAX);
    // RULE_02 clamp age time
    wire age_t  age_clamp = age_big ? `AGE_MAX : (age_wr < `AGE_MIN) ? `AGE_MIN : age_wr;
    wire logic [4:0] stat_w = {res_static_r, add_full_r, res_eot_r, res_found_r, busy_w};

    assign pready    = 1'b1;
    assign pslverr   = psel & penable & ~map_ok_w;
    assign prdata    = prdata_r;
    assign frm_ready = idle_w && !cmd_pend_r;
    assign frm_done  = frm_done_r;
    assign frm_drop  = frm_drop_r;

    // Read selection
    wire logic [31:0] rdata_w =
        (paddr == `REG_CTRL)      ? {31'h0, age_dis_r} :
        (paddr == `REG_AGE)       ? {12'h000, age_time_r} :
        (paddr == `REG_LEARN)     ? {8'h00, learn_mode_r} :
        (paddr == `REG_OWNED)     ? {20'h00000, learn_owned} :
        (paddr == `REG_KEY_VID)   ? {20'h00000, kvid_r} :
        (paddr == `REG_KEY_MLO)   ? kmac_r[31:0] :
        (paddr == `REG_KEY_MHI)   ? {16'h0000, kmac_r[47:32]} :
        (paddr == `REG_KEY_PORTS) ? {20'h00000, kports_r} :
        (paddr == `REG_CMD)       ? {27'h0, stat_w} :
        (paddr == `REG_RES_VID)   ? {20'h00000, res_vid_r} :
        (paddr == `REG_RES_MLO)   ? res_mac_r[31:0] :
        (paddr == `REG_RES_MHI)   ? {16'h0000, res_mac_r[47:32]} :
        (paddr == `REG_RES_PORTS) ? {20'h00000, res_ports_r} : 32'h0;

    // Command select: lowest set bit wins
    wire op_t cmd_sel_w =
        pwdata[`CMD_LOOKUP] ? OP_LOOKUP :
        pwdata[`CMD_NEXT]   ? OP_NEXT :
        pwdata[`CMD_ADD]    ? OP_ADD : OP_MARK;
    wire logic cmd_any_w = |pwdata[`CMD_MARK:`CMD_LOOKUP];

    ////////////////////////////////////////////////////////////////////////////
    // Configuration registers

    // Learning mode: a port owned elsewhere keeps its old mode on write
    logic [23:0] learn_nxt;
    logic [23:0] own_mask_w;
    always_comb begin
        learn_nxt = learn_mode_r;
        own_mask_w = '0;
        for (int p = 0; p < `NUM_PORTS; p++) begin
            own_mask_w[2*p +: 2] = {2{learn_owned[p]}};
            // RULE_13 owned ports ignored
            if (!learn_owned[p]) begin
                learn_nxt[2*p +: 2] = pwdata[2*p +: 2];
            end
        end
    end

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            age_dis_r    <= 1'b0;
            // RULE_01 default 300 s
            age_time_r   <= `AGE_DEF;
            learn_mode_r <= `LEARN_DEF;
            kvid_r       <= '0;
            kmac_r       <= '0;
            kports_r     <= '0;
            prdata_r     <= '0;
        end else begin
            if (setup_w) begin
                prdata_r <= rdata_w;
            end
            if (wr_w && paddr == `REG_CTRL) begin
                age_dis_r <= pwdata[`CTRL_AGE_DIS];
            end
            if (wr_w && paddr == `REG_AGE) begin
                age_time_r <= age_clamp;
            end
            if (wr_learn) begin
                learn_mode_r <= learn_nxt;
            end
            if (wr_w && paddr == `REG_KEY_VID) begin
                kvid_r <= pwdata[11:0];
            end
            if (wr_w && paddr == `REG_KEY_MLO) begin
                kmac_r[31:0] <= pwdata;
            end
            if (wr_w && paddr == `REG_KEY_MHI) begin
                kmac_r[47:32] <= pwdata[15:0];
            end
            if (wr_w && paddr == `REG_KEY_PORTS) begin
                kports_r <= pwdata[11:0];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // One-second tick

    // RULE_16 aging tick
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            tick_cnt_r <= '0;
            tick_r     <= 1'b0;
        end else begin
            tick_r     <= (tick_cnt_r == 27'(TICK_CYCLES - 1));
            tick_cnt_r <= (tick_cnt_r == 27'(TICK_CYCLES - 1)) ? '0 : tick_cnt_r + 27'h1;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Sequential search over every slot

    // Slots 0..63 hold static entries, 64..127 dynamic ones
    wire key_t ent_key = key_of(vid_r[idx_r], mac_r[idx_r]);
    wire logic ent_v   = valid_r[idx_r];
    wire logic hit_w   = ent_v && (ent_key == skey_r);
    // RULE_08 key order compare
    wire logic after_w = ent_v && ((op_r == OP_NEXT) ? (ent_key > skey_r) : (ent_key >= skey_r));
    wire logic better_w = after_w && (!bf_r || ent_key < bkey_r);
    wire logic last_w  = (idx_r == 7'h7f);

    // Frame decision inputs, valid at ST_DONE
    wire logic [1:0] fmode_w = (fport_r < 4'hc) ? learn_mode_r[2*fport_r +: 2] : LM_DISABLE;
    wire logic st_hit_w  = hit_r && !hit_idx_r[6];
    wire logic dyn_hit_w = hit_r && hit_idx_r[6];
    wire logic done_w    = (st_r == ST_DONE);
    wire logic lrn_done  = done_w && (op_r == OP_LEARN);
    // RULE_06 secure drops non-static
    wire logic drop_w    = (fmode_w == LM_SECURE) && !st_hit_w;
    // RULE_04 auto inserts unknown source
    wire logic insert_w  = (fmode_w == LM_AUTO) && !hit_r && fd_f_r;
    // RULE_16 refresh on hit
    wire logic refresh_w = (fmode_w == LM_AUTO) && dyn_hit_w;

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            st_r       <= ST_IDLE;
            op_r       <= OP_LOOKUP;
            cmd_pend_r <= 1'b0;
            cmd_op_r   <= OP_LOOKUP;
            idx_r      <= '0;
            skey_r     <= '0;
            fport_r    <= '0;
            {hit_r, bf_r, fs_f_r, fd_f_r} <= '0;
            {hit_idx_r, bidx_r, fs_idx_r, fd_idx_r} <= '0;
            bkey_r     <= '0;
        end else begin
            // Lookup, next, add and mark written while busy are dropped; software polls busy first
            if (wr_cmd && cmd_any_w && !busy_w) begin
                cmd_pend_r <= 1'b1;
                cmd_op_r   <= cmd_sel_w;
            end
            case (st_r)
                ST_IDLE: begin
                    idx_r <= '0;
                    {hit_r, bf_r, fs_f_r, fd_f_r} <= '0;
                    if (start_cmd) begin
                        cmd_pend_r <= 1'b0;
                        op_r       <= cmd_op_r;
                        skey_r     <= key_of(kvid_r, kmac_r);
                        st_r       <= ST_SCAN;
                    end else if (start_frm) begin
                        op_r    <= OP_LEARN;
                        fport_r <= frm_port;
                        skey_r  <= key_of(frm_vid, frame_source_station_address);
                        st_r    <= ST_SCAN;
                    end
                end
                ST_SCAN: begin
                    if (hit_w) begin
                        hit_r     <= 1'b1;
                        hit_idx_r <= idx_r;
                    end
                    // RULE_11 keep least following key
                    if (better_w) begin
                        bf_r   <= 1'b1;
                        bidx_r <= idx_r;
                        bkey_r <= ent_key;
                    end
                    if (!ent_v && !idx_r[6] && !fs_f_r) begin
                        fs_f_r   <= 1'b1;
                        fs_idx_r <= idx_r;
                    end
                    if (!ent_v && idx_r[6] && !fd_f_r) begin
                        fd_f_r   <= 1'b1;
                        fd_idx_r <= idx_r;
                    end
                    idx_r <= idx_r + 7'h1;
                    if (last_w) begin
                        st_r <= ST_DONE;
                    end
                end
                ST_DONE: st_r <= ST_IDLE;
                default: st_r <= ST_IDLE;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Results and frame answer

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            {res_found_r, res_eot_r, add_full_r, res_static_r} <= '0;
            res_vid_r   <= '0;
            res_mac_r   <= '0;
            res_ports_r <= '0;
            frm_done_r  <= 1'b0;
            frm_drop_r  <= 1'b0;
        end else begin
            frm_done_r <= lrn_done;
            if (lrn_done) begin
                frm_drop_r <= drop_w;
            end
            if (done_w && (op_r == OP_LOOKUP || op_r == OP_NEXT)) begin
                res_found_r  <= bf_r;
                // RULE_12 end of table
                res_eot_r    <= !bf_r;
                res_vid_r    <= bf_r ? vid_r[bidx_r] : '0;
                res_mac_r    <= bf_r ? mac_r[bidx_r] : '0;
                res_ports_r  <= bf_r ? ports_r[bidx_r] : '0;
                // RULE_14 entry type
                res_static_r <= bf_r && !bidx_r[6];
            end
            // RULE_07 refuse beyond 64 static
            if (done_w && op_r == OP_ADD) begin
                add_full_r <= !st_hit_w && !fs_f_r;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Table contents

    // Aging first, updates later, so a refresh in the tick cycle survives
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            valid_r <= '0;
            del_r   <= '0;
        end else begin
            // RULE_03 aging disable holds
            if (tick_r && !age_dis_r) begin
                // RULE_15 only dynamic slots age
                for (int i = `STATIC_MAX; i < `TABLE_SIZE; i++) begin
                    // RULE_01 remove after age time
                    if (valid_r[i] && (age_r[i] + 20'h1 >= age_time_r)) begin
                        valid_r[i] <= 1'b0;
                    end else begin
                        age_r[i] <= age_r[i] + 20'h1;
                    end
                end
            end
            // RULE_10 remove marked on commit
            if (commit_w) begin
                for (int i = 0; i < `STATIC_MAX; i++) begin
                    if (del_r[i]) begin
                        valid_r[i] <= 1'b0;
                        del_r[i]   <= 1'b0;
                    end
                end
            end
            if (done_w && op_r == OP_MARK && st_hit_w) begin
                del_r[hit_idx_r[5:0]] <= 1'b1;
            end
            // RULE_09 static entry fields
            if (done_w && op_r == OP_ADD) begin
                if (st_hit_w) begin
                    ports_r[hit_idx_r] <= kports_r;
                end else if (fs_f_r) begin
                    valid_r[fs_idx_r] <= 1'b1;
                    vid_r[fs_idx_r]   <= kvid_r;
                    mac_r[fs_idx_r]   <= kmac_r;
                    ports_r[fs_idx_r] <= kports_r;
                    del_r[fs_idx_r[5:0]] <= 1'b0;
                    // The static copy supersedes a learned one
                    if (dyn_hit_w) begin
                        valid_r[hit_idx_r] <= 1'b0;
                    end
                end
            end
            // RULE_05 learning needs auto mode
            if (lrn_done && insert_w) begin
                valid_r[fd_idx_r] <= 1'b1;
                vid_r[fd_idx_r]   <= skey_r[59:48];
                mac_r[fd_idx_r]   <= skey_r[47:0];
                ports_r[fd_idx_r] <= port_bit(fport_r);
                age_r[fd_idx_r]   <= '0;
            end
            if (lrn_done && refresh_w) begin
                valid_r[hit_idx_r] <= 1'b1;
                age_r[hit_idx_r]   <= '0;
                ports_r[hit_idx_r] <= port_bit(fport_r);
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Assertions

    a_age_clamped: assert property ( // RULE_02
        @(posedge clk_sys) disable iff (!arst_n)
        wr_w && paddr == `REG_AGE |=> age_time_r >= `AGE_MIN && age_time_r <= `AGE_MAX)
        else $error("age time left its range");
    a_owned_hold: assert property ( // RULE_13
        @(posedge clk_sys) disable iff (!arst_n)
        wr_learn |=> ((learn_mode_r ^ $past(learn_mode_r)) & $past(own_mask_w)) == 24'h0)
        else $error("owned learning mode changed");
    a_secure_drop: assert property ( // RULE_06
        @(posedge clk_sys) disable iff (!arst_n)
        lrn_done && fmode_w == LM_SECURE && !st_hit_w |=> frm_done && frm_drop)
        else $error("secure port passed unknown source");
    a_disable_nolearn: assert property ( // RULE_05
        @(posedge clk_sys) disable iff (!arst_n)
        lrn_done && fmode_w == LM_DISABLE |=>
        ((valid_r[127:64] & ~$past(valid_r[127:64])) == 64'h0))
        else $error("disabled port learned");
    a_auto_insert: assert property ( // RULE_04
        @(posedge clk_sys) disable iff (!arst_n)
        lrn_done && fmode_w == LM_AUTO && !hit_r && fd_f_r |=> valid_r[$past(fd_idx_r)])
        else $error("auto port did not learn");
    a_static_noage: assert property ( // RULE_15
        @(posedge clk_sys) disable iff (!arst_n)
        !commit_w |=> (($past(valid_r[63:0]) & ~valid_r[63:0]) == 64'h0))
        else $error("static entry lost without commit");
    a_age_disabled: assert property ( // RULE_03
        @(posedge clk_sys) disable iff (!arst_n)
        age_dis_r && !(done_w && op_r == OP_ADD) |=>
        (($past(valid_r[127:64]) & ~valid_r[127:64]) == 64'h0))
        else $error("dynamic entry aged while disabled");
    a_add_full: assert property ( // RULE_07
        @(posedge clk_sys) disable iff (!arst_n)
        done_w && op_r == OP_ADD && !st_hit_w && !fs_f_r |=> add_full_r ##1 add_full_r)
        else $error("full table not flagged");
    a_scan_end: assert property ( // RULE_12
        @(posedge clk_sys) disable iff (!arst_n)
        done_w && op_r == OP_NEXT && !bf_r |=> res_eot_r && !res_found_r)
        else $error("end of table not flagged");

endmodule // mac_table

// ---- tb/frame_source.sv ----
// Forwarding-path model that offers received-frame source reports
`timescale 1ns/1ps
module frame_source
    import mac_table_pkg::*;
(
    // Clock
    input  wire logic  clk_sys,
    // Report toward the table
    output logic       frm_valid,
    input  wire logic  frm_ready,
    output logic [3:0] frm_port,
    output vid_t       frm_vid,
    output mac_t       src_mac,
    input  wire logic  frm_done,
    input  wire logic  frm_drop
);
    initial begin
        frm_valid = 1'b0;
        frm_port = 4'h0;
        frm_vid = '0;
        src_mac = '0;
    end
    // Offer after gap idle cycles, hold until taken, then wait for the decision
    task automatic offer(input logic [3:0] p, input vid_t v, input mac_t m, input int gap,
                         output logic drop);
        repeat (gap) @(posedge clk_sys);
        frm_valid <= 1'b1;
        frm_port <= p;
        frm_vid <= v;
        src_mac <= m;
        @(posedge clk_sys);
        while (frm_ready !== 1'b1) @(posedge clk_sys);
        frm_valid <= 1'b0;
        // Released lines show the inverse so a stale key cannot pass
        frm_port <= ~p;
        frm_vid <= ~v;
        src_mac <= ~m;
        @(posedge clk_sys);
        while (frm_done !== 1'b1) @(posedge clk_sys);
        drop = frm_drop;
    endtask
endmodule // frame_source

// ---- tb/mac_table_tb.sv ----
// Self-checking bench for the station address table
`timescale 1ns/1ps
`include "mac_table_map.svh"
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin bad_count++; \
    $display("ERROR t=%0t got=%h exp=%h", $time, (a), (b)); end end
module mac_table_tb;
    import mac_table_pkg::*;
    localparam int TICKS = 100;
    logic        clk_sys = 1'b0;
    logic        arst_n = 1'b0;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [11:0] learn_owned = 12'h000;
    logic [31:0] prdata, q;
    logic        pready, pslverr, frm_valid, frm_ready, frm_done, frm_drop, e, h;
    logic [3:0]  frm_port;
    vid_t        frm_vid;
    mac_t        src_mac;
    // Reference table: bit 12 static, bits 11:0 port members
    bit [12:0]   tab[bit [59:0]];
    bit [59:0]   last, kd, ks0, ks1, kx, dq[$];
    logic [23:0] lrn;
    int          bad_count = 0;
    int          n_checks = 0;
    int          cycles = 0;
    int unsigned agev[4] = '{9, 10, 1000000, 1000001};
    mac_table #(.TICK_CYCLES(TICKS)) mac_table_inst (.clk_sys(clk_sys), .arst_n(arst_n),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .frm_valid(frm_valid),
        .frm_ready(frm_ready), .frm_port(frm_port), .frm_vid(frm_vid),
        .frame_source_station_address(src_mac), .frm_done(frm_done), .frm_drop(frm_drop),
        .learn_owned(learn_owned));
    frame_source frame_source_inst (.clk_sys(clk_sys), .frm_valid(frm_valid),
        .frm_ready(frm_ready), .frm_port(frm_port), .frm_vid(frm_vid), .src_mac(src_mac),
        .frm_done(frm_done), .frm_drop(frm_drop));
    always #5 clk_sys = ~clk_sys;
    // Hang guard, well above the expected run length
    always @(posedge clk_sys) begin
        cycles <= cycles + 1;
        if (cycles == 80000) begin
            bad_count++;
            complete_run();
        end
    end
    task automatic complete_run();
        $display("checks=%0d mismatches=%0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    // One APB transfer; held until pready is sampled high
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] rq, output logic err);
        @(posedge clk_sys);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk_sys);
        penable <= 1'b1;
        @(posedge clk_sys);
        while (pready !== 1'b1) @(posedge clk_sys);
        rq = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] x;
        logic        r;
        apb(1'b1, a, d, x, r);
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] x);
        logic r;
        apb(1'b0, a, 32'h0, x, r);
    endtask
    // Issue a command and poll until the table is idle again
    task automatic cmd(input logic [31:0] c, output logic [31:0] st);
        wr(`REG_CMD, c);
        st = 32'h1;
        while (st[`ST_BUSY] !== 1'b0) rd(`REG_CMD, st);
    endtask
    task automatic key(input bit [59:0] k);
        wr(`REG_KEY_VID, {20'h0, k[59:48]});
        wr(`REG_KEY_MLO, k[31:0]);
        wr(`REG_KEY_MHI, {16'h0, k[47:32]});
    endtask
    function automatic int nstat();
        nstat = 0;
        foreach (tab[i]) nstat += tab[i][12];
    endfunction
    // Least reference key at or above the start (strictly above for next)
    function automatic bit seek(input bit [59:0] k, input bit nx, output bit [59:0] r);
        seek = 1'b0;
        r = '0;
        foreach (tab[i]) if (!seek && (i > k || (!nx && i == k))) begin
            seek = 1'b1;
            r = i;
        end
    endfunction
    task automatic look(input bit [59:0] k, input bit nx, output logic hit);
        logic [31:0] st, v, lo, hi, pm;
        bit [12:0]   ent;
        bit [59:0]   r;
        hit = seek(k, nx, r);
        ent = hit ? tab[r] : 13'h0;
        key(k);
        cmd({30'h0, nx, !nx}, st);
        rd(`REG_RES_VID, v);
        rd(`REG_RES_MLO, lo);
        rd(`REG_RES_MHI, hi);
        rd(`REG_RES_PORTS, pm);
        `CHK({st[4], st[2:1]}, {ent[12], !hit, hit})
        `CHK({v[11:0], hi[15:0], lo, pm[11:0]}, hit ? {r, ent[11:0]} : 72'h0)
        last = r;
    endtask
    task automatic scan();
        logic g;
        look(60'h0, 1'b0, g);
        for (int i = 0; i < 80 && g; i++) look(last, 1'b1, g);
    endtask
    task automatic add(input bit [59:0] k, input logic [11:0] pm);
        logic [31:0] st;
        bit          full;
        full = !(tab.exists(k) && tab[k][12]) && nstat() >= `STATIC_MAX;
        wr(`REG_KEY_PORTS, {20'h0, pm});
        key(k);
        cmd(32'h4, st);
        if (!full) tab[k] = {1'b1, pm};
        `CHK(st[`ST_FULL], full)
    endtask
    task automatic frame(input logic [3:0] p, input bit [59:0] k, input int gap);
        logic drop;
        bit   st;
        st = tab.exists(k) && tab[k][12];
        frame_source_inst.offer(p, k[59:48], k[47:0], gap, drop);
        if (lrn[2*p +: 2] == 2'd0 && !st) tab[k] = {1'b0, 12'h1 << p};
        `CHK(drop, lrn[2*p +: 2] == 2'd2 && !st)
    endtask
    initial begin
        void'($urandom(93));
        kd = {12'h001, 16'($urandom()), $urandom()};
        ks1 = {12'h001, 16'($urandom()), $urandom()};
        ks0 = {12'h002, 48'h0};
        kx = {12'h003, 16'($urandom()), $urandom()};
        lrn = 24'h000000;
        repeat (12) @(posedge clk_sys);
        arst_n <= 1'b1;
        rd(`REG_AGE, q);
        `CHK(q, 32'd300)
        apb(1'b0, 8'h34, 32'h0, q, e);
        `CHK(e, 1'b1)
        foreach (agev[i]) begin
            wr(`REG_AGE, agev[i]);
            rd(`REG_AGE, q);
            `CHK(q, agev[i] < 10 ? 10 : agev[i] > 1000000 ? 1000000 : agev[i])
        end
        // Short age with aging off; port 3 is owned so its write is ignored
        wr(`REG_AGE, 32'd10);
        wr(`REG_CTRL, 32'h1);
        learn_owned <= 12'h008;
        wr(`REG_LEARN, 32'h364);
        lrn = 24'h000324;
        rd(`REG_LEARN, q);
        `CHK(q[23:0], lrn)
        add(ks1, 12'h801);
        add(ks0, 12'h004);
        add(ks0, 12'h00c);
        frame(4'd0, kd, 0);
        frame(4'd0, kd, 3);
        frame(4'd1, kx, 0);
        frame(4'd2, kx, 5);
        frame(4'd2, ks1, 0);
        frame(4'd3, kx + 1, 0);
        frame(4'd4, kx + 2, 0);
        scan();
        repeat (1500) @(posedge clk_sys);
        look(kd, 1'b0, h);
        wr(`REG_CTRL, 32'h0);
        frame(4'd0, kd, 0);
        repeat (600) @(posedge clk_sys);
        look(kd, 1'b0, h);
        repeat (500) @(posedge clk_sys);
        foreach (tab[k]) if (!tab[k][12]) dq.push_back(k);
        foreach (dq[i]) tab.delete(dq[i]);
        scan();
        key(ks0);
        cmd(32'h8, q);
        look(ks0, 1'b0, h);
        wr(`REG_CMD, 32'h10);
        tab.delete(ks0);
        look(ks0, 1'b0, h);
        for (int i = 0; i < 70; i++) add({12'h0ff, 48'(i)}, 12'h001);
        scan();
        complete_run();
    end
endmodule // mac_table_tb
